/* hw/tbm_pkg.sv */
// Purpose: shared constants of the temperature and battery monitor readout
// Assumes: 8-bit register port, 16-bit byte addresses, 10 MHz core clock
// Notes:   every offset lives here; some field positions and reset values sit in tbm_readout
`default_nettype none

package tbm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [15:0] ADDR_OSC_TEST    = 16'h2500;
    localparam logic [15:0] ADDR_LOAD_CTRL   = 16'h2704;
    localparam logic [15:0] ADDR_TEMP_HIGH   = 16'h2881;
    localparam logic [15:0] ADDR_TEMP_LOW    = 16'h2882;
    localparam logic [15:0] ADDR_BATT_RESULT = 16'h2885;
    localparam logic [15:0] ADDR_MEAS_CFG    = 16'h28a0;
    localparam logic [15:0] ADDR_MEAS_CTRL   = 16'h28b4;
    localparam logic [15:0] ADDR_REMOTE_CTRL = 16'h28b8;
    localparam logic [15:0] ADDR_REMOTE_SUP  = 16'h28b9;
    localparam logic [15:0] ADDR_REMOTE_THI  = 16'h28ba;
    localparam logic [15:0] ADDR_REMOTE_TLO  = 16'h28bb;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BIT_LOAD_EN       = 3;
    localparam int BIT_BATT_WITH_TMP = 4;
    localparam int BIT_PWR_SEL       = 6;
    localparam int BIT_TRIGGER       = 6;
    localparam int BIT_REMOTE_START  = 0;
    localparam int BIT_REMOTE_BUSY   = 1;
    localparam int TEMP_LOW_LSB      = 5;

    ////////////////////////////////////////////////////////////////////////
    // reset values and encodings
    localparam logic [1:0] OSC_TEST_RESET = 2'h0;
    localparam logic [1:0] OSC_TEST_NORMAL = 2'h0;
    localparam logic [2:0] INTERVAL_RESET = 3'h0;
    localparam logic [2:0] INTERVAL_MANUAL = 3'h0;
    localparam logic [2:0] INTERVAL_CONT   = 3'h7;
    localparam logic [2:0] INTERVAL_EXP_BASE = 3'h3;
    localparam logic [1:0] REMOTE_CMD_SUPPLY = 2'h1;
    localparam logic [1:0] REMOTE_CMD_TEMP   = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_FREQ_HZ = 10_000_000;
    localparam int TICK_S      = 1;
    localparam int TICK_CYCLES = TICK_S * CLK_FREQ_HZ;

endpackage : tbm_pkg

`default_nettype wire

/* hw/tbm_interval_timer.sv */
// Purpose: automatic measurement scheduler, one due pulse per period
// Assumes: interval code 1..4 gives 2^(3+code) seconds; 5 and 6 wrap the 3-bit shift sum to 1 and 2 seconds
// Notes:   counts restart whenever the interval code changes
`default_nettype none

module tbm_interval_timer #(
    parameter int TICK_CYCLES = tbm_pkg::TICK_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [2:0] interval,
    output var  logic       due
);

    logic [23:0] cyc_q;
    logic [9:0]  sec_q;
    logic [2:0]  last_q;
    logic        tick;
    logic [9:0]  period;
    logic        auto_mode;

    assign tick      = (cyc_q == 24'(TICK_CYCLES - 1));
    assign period    = 10'h001 << (tbm_pkg::INTERVAL_EXP_BASE + interval);
    assign auto_mode = (interval != tbm_pkg::INTERVAL_MANUAL)
                    && (interval != tbm_pkg::INTERVAL_CONT);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cyc_q <= 24'h000000;
        end else if (tick || interval != last_q) begin
            cyc_q <= 24'h000000;
        end else begin
            cyc_q <= cyc_q + 24'h000001;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sec_q <= 10'h000;
            due   <= 1'b0;
        end else if (!auto_mode || interval != last_q) begin
            sec_q <= 10'h000;
            due   <= 1'b0;
        end else if (tick) begin
            due   <= (sec_q == period - 10'h001);
            sec_q <= (sec_q == period - 10'h001) ? 10'h000 : sec_q + 10'h001;
        end else begin
            due   <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            last_q <= tbm_pkg::INTERVAL_RESET;
        end else begin
            last_q <= interval;
        end
    end

endmodule : tbm_interval_timer

`default_nettype wire

/* hw/tbm_remote_fetch.sv */
// Purpose: fetches supply then temperature result from the remote sensor
// Assumes: remote answers each command once with rsp_valid
// Notes:   no timeout; a silent remote keeps busy high
`default_nettype none

module tbm_remote_fetch (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        start,
    input  wire logic        rsp_valid,
    input  wire logic [10:0] rsp_data,
    output var  logic        cmd_valid,
    output var  logic [1:0]  cmd_code,
    output var  logic        busy,
    output var  logic [7:0]  supply_q,
    output var  logic [10:0] temp_q
);

    typedef enum logic [1:0] {TBM_RF_IDLE, TBM_RF_SUP, TBM_RF_TMP} tbm_rf_state_t;
    tbm_rf_state_t state_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q   <= TBM_RF_IDLE;
            cmd_valid <= 1'b0;
            cmd_code  <= 2'h0;
            busy      <= 1'b0;
            supply_q  <= 8'h00;
            temp_q    <= 11'h000;
        end else begin
            cmd_valid <= 1'b0;
            case (state_q)
                TBM_RF_IDLE: begin
                    if (start) begin
                        state_q   <= TBM_RF_SUP;
                        cmd_valid <= 1'b1;
                        cmd_code  <= tbm_pkg::REMOTE_CMD_SUPPLY;
                        busy      <= 1'b1;
                    end
                end
                TBM_RF_SUP: begin
                    if (rsp_valid) begin
                        supply_q  <= rsp_data[7:0];
                        state_q   <= TBM_RF_TMP;
                        cmd_valid <= 1'b1;
                        cmd_code  <= tbm_pkg::REMOTE_CMD_TEMP;
                    end
                end
                TBM_RF_TMP: begin
                    if (rsp_valid) begin
                        temp_q  <= rsp_data;
                        state_q <= TBM_RF_IDLE;
                        busy    <= 1'b0;
                    end
                end
                default: begin
                    state_q <= TBM_RF_IDLE;
                    busy    <= 1'b0;
                end
            endcase
        end
    end

endmodule : tbm_remote_fetch

`default_nettype wire

/* hw/tbm_readout.sv */
// Purpose: register slice of the temperature sensor and battery monitor
// Assumes: inputs synchronous to core_clk; analog side pulses meas_done
// Notes:   read data appear one cycle after the read strobe, only then
//
// Our own choice: the address-and-strobe port.
`default_nettype none

// How it works
// - oscillator test field resets to 00, normal; other codes are factory test
// - nonzero test field keeps the sensor oscillator running all the time
// - result high byte holds bits 10:3, next byte bits 7:5 hold bits 2:0
// - battery enable set: every temperature measurement also measures battery
// - battery outcome lands in a read-only byte; writes are dropped
// - mission mode: load enable bit connects the 100 uA battery load
// - sleep mode never connects the battery load
// - remote supply fetch reads both supply and temperature results
// - interval 0 manual, 1..4 every 2^(3+n) s, 5 and 6 every 1 and 2 s (3-bit shift sum wraps), 7 continuous
// - manual trigger starts one measurement, clears on completion, sleep ignores
module tbm_readout #(
    parameter int TICK_CYCLES = tbm_pkg::TICK_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        mission_mode,
    input  wire logic        sleep_mode,
    input  wire logic        meas_done,
    input  wire logic [10:0] meas_temp,
    input  wire logic [7:0]  meas_batt,
    output var  logic        meas_start,
    output var  logic        meas_batt_en,
    output var  logic        osc_run_continuous,
    output var  logic        sensor_pwr_sel,
    output var  logic        battery_load_on,
    input  wire logic        remote_rsp_valid,
    input  wire logic [10:0] remote_rsp_data,
    output logic             remote_cmd_valid,
    output logic [1:0]       remote_cmd_code
);

    typedef enum logic [1:0] {TBM_IDLE, TBM_MEAS} tbm_state_t;

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [1:0]  osc_test_q;
    logic        load_en_q;
    logic [2:0]  interval_q;
    logic        batt_with_temp_q;
    logic        pwr_sel_q;
    logic        trigger_q;
    logic        trigger_d;
    logic [10:0] temp_result_q;
    logic [7:0]  batt_result_q;
    logic        remote_start_q;
    logic        remote_busy;
    logic [7:0]  remote_supply;
    logic [10:0] remote_temp;

    tbm_state_t  state_q;
    logic        manual_run_q;
    logic        auto_due;
    logic        start_now;
    logic        start_manual;
    logic        done_now;
    logic [7:0]  rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // write decode
    logic wr_osc;
    logic wr_load;
    logic wr_cfg;
    logic wr_ctrl;
    logic wr_remote;

    assign wr_osc    = reg_wr && (reg_addr == tbm_pkg::ADDR_OSC_TEST);
    assign wr_load   = reg_wr && (reg_addr == tbm_pkg::ADDR_LOAD_CTRL);
    assign wr_cfg    = reg_wr && (reg_addr == tbm_pkg::ADDR_MEAS_CFG);
    assign wr_ctrl   = reg_wr && (reg_addr == tbm_pkg::ADDR_MEAS_CTRL);
    assign wr_remote = reg_wr && (reg_addr == tbm_pkg::ADDR_REMOTE_CTRL);

    ////////////////////////////////////////////////////////////////////////
    // oscillator test field
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            osc_test_q <= tbm_pkg::OSC_TEST_RESET;
        end else if (wr_osc) begin
            osc_test_q <= reg_wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // battery load control
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            load_en_q <= 1'b0;
        end else if (wr_load) begin
            load_en_q <= reg_wdata[tbm_pkg::BIT_LOAD_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // measurement configuration; the reserved top bit is held at zero
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            interval_q       <= tbm_pkg::INTERVAL_RESET;
            batt_with_temp_q <= 1'b0;
            pwr_sel_q        <= 1'b0;
        end else if (wr_cfg) begin
            interval_q       <= reg_wdata[2:0];
            batt_with_temp_q <= reg_wdata[tbm_pkg::BIT_BATT_WITH_TMP];
            pwr_sel_q        <= reg_wdata[tbm_pkg::BIT_PWR_SEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // manual trigger: a software set in the completion cycle wins
    logic trig_set;
    logic trig_clr_sw;

    assign trig_set    = wr_ctrl && reg_wdata[tbm_pkg::BIT_TRIGGER]
                      && (interval_q == tbm_pkg::INTERVAL_MANUAL)
                      && !sleep_mode;
    assign trig_clr_sw = wr_ctrl && !reg_wdata[tbm_pkg::BIT_TRIGGER];

    always_comb begin
        trigger_d = trigger_q;
        if (trig_set) begin
            trigger_d = 1'b1;
        end else if (trig_clr_sw) begin
            trigger_d = 1'b0;
        end else if (done_now && manual_run_q) begin
            trigger_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            trigger_q <= 1'b0;
        end else begin
            trigger_q <= trigger_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // measurement scheduling
    tbm_interval_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .interval (interval_q),
        .due      (auto_due)
    );

    // a due pulse landing mid-measurement is dropped, not queued
    assign start_manual = trigger_q && !manual_run_q
                       && (interval_q == tbm_pkg::INTERVAL_MANUAL)
                       && !sleep_mode;
    assign start_now = (state_q == TBM_IDLE)
                    && (start_manual || auto_due
                        || interval_q == tbm_pkg::INTERVAL_CONT);
    assign done_now  = (state_q == TBM_MEAS) && meas_done;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q      <= TBM_IDLE;
            manual_run_q <= 1'b0;
        end else begin
            case (state_q)
                TBM_IDLE: begin
                    if (start_now) begin
                        state_q      <= TBM_MEAS;
                        manual_run_q <= start_manual;
                    end
                end
                TBM_MEAS: begin
                    if (meas_done) begin
                        state_q      <= TBM_IDLE;
                        manual_run_q <= 1'b0;
                    end
                end
                default: begin
                    state_q      <= TBM_IDLE;
                    manual_run_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sensor side controls
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meas_start <= 1'b0;
        end else begin
            meas_start <= start_now;
        end
    end

    // battery choice is latched per measurement so a mid-run write cannot split it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meas_batt_en <= 1'b0;
        end else if (start_now) begin
            meas_batt_en <= batt_with_temp_q;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            osc_run_continuous <= 1'b0;
        end else begin
            osc_run_continuous <= (osc_test_q != tbm_pkg::OSC_TEST_NORMAL);
        end
    end

    // in sleep the sensor always runs from the battery supply
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sensor_pwr_sel <= 1'b0;
        end else begin
            sensor_pwr_sel <= pwr_sel_q && !sleep_mode;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            battery_load_on <= 1'b0;
        end else begin
            battery_load_on <= load_en_q && mission_mode
                            && !sleep_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // results; hardware is the only writer
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            temp_result_q <= 11'h000;
        end else if (done_now) begin
            temp_result_q <= meas_temp;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            batt_result_q <= 8'h00;
        end else if (done_now && meas_batt_en) begin
            batt_result_q <= meas_batt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // remote sensor fetch
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            remote_start_q <= 1'b0;
        end else begin
            remote_start_q <= wr_remote && reg_wdata[tbm_pkg::BIT_REMOTE_START]
                           && !remote_busy;
        end
    end

    tbm_remote_fetch u_remote (
        .core_clk  (core_clk),
        .reset     (reset),
        .start     (remote_start_q),
        .rsp_valid (remote_rsp_valid),
        .rsp_data  (remote_rsp_data),
        .cmd_valid (remote_cmd_valid),
        .cmd_code  (remote_cmd_code),
        .busy      (remote_busy),
        .supply_q  (remote_supply),
        .temp_q    (remote_temp)
    );

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            tbm_pkg::ADDR_OSC_TEST: begin
                rdata_d[1:0] = osc_test_q;
            end
            tbm_pkg::ADDR_LOAD_CTRL: begin
                rdata_d[tbm_pkg::BIT_LOAD_EN] = load_en_q;
            end
            tbm_pkg::ADDR_TEMP_HIGH: begin
                rdata_d = temp_result_q[10:3];
            end
            tbm_pkg::ADDR_TEMP_LOW: begin
                rdata_d[7:tbm_pkg::TEMP_LOW_LSB] = temp_result_q[2:0];
            end
            tbm_pkg::ADDR_BATT_RESULT: begin
                rdata_d = batt_result_q;
            end
            tbm_pkg::ADDR_MEAS_CFG: begin
                rdata_d[2:0] = interval_q;
                rdata_d[tbm_pkg::BIT_BATT_WITH_TMP] = batt_with_temp_q;
                rdata_d[tbm_pkg::BIT_PWR_SEL] = pwr_sel_q;
            end
            tbm_pkg::ADDR_MEAS_CTRL: begin
                rdata_d[tbm_pkg::BIT_TRIGGER] = trigger_q;
            end
            tbm_pkg::ADDR_REMOTE_CTRL: begin
                rdata_d[tbm_pkg::BIT_REMOTE_BUSY] = remote_busy || remote_start_q;
            end
            tbm_pkg::ADDR_REMOTE_SUP: begin
                rdata_d = remote_supply;
            end
            tbm_pkg::ADDR_REMOTE_THI: begin
                rdata_d = remote_temp[10:3];
            end
            tbm_pkg::ADDR_REMOTE_TLO: begin
                rdata_d[7:tbm_pkg::TEMP_LOW_LSB] = remote_temp[2:0];
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : tbm_readout

`default_nettype wire

/* tb/tbm_readout_checker.sv */
// Purpose: port-level checks of the monitor readout
// Assumes: one clock domain, async active-high reset
// Notes:   bound to every tbm_readout instance
`default_nettype none

module tbm_readout_checker (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        mission_mode,
    input wire logic        sleep_mode,
    input wire logic        meas_start,
    input wire logic        osc_run_continuous,
    input wire logic        battery_load_on,
    input wire logic        remote_rsp_valid,
    input wire logic        remote_cmd_valid,
    input wire logic [1:0]  remote_cmd_code
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_LOAD_SLEEP: assert property ($past(sleep_mode) |-> !battery_load_on)
        else $error("load applied in sleep");
    AST_LOAD_MISSION: assert property (battery_load_on |-> $past(mission_mode))
        else $error("load applied outside mission");
    AST_LOAD_ON: assert property ((reg_wr && reg_addr == tbm_pkg::ADDR_LOAD_CTRL
        && reg_wdata[tbm_pkg::BIT_LOAD_EN]) ##1 (mission_mode && !sleep_mode && !reg_wr)[*2]
        |-> battery_load_on) else $error("load not applied");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_OSC_ON: assert property (reg_wr && reg_addr == tbm_pkg::ADDR_OSC_TEST
        && reg_wdata[1:0] != 2'h0 |-> ##[1:2] osc_run_continuous) else $error("osc not on");
    AST_OSC_OFF: assert property (reg_wr && reg_addr == tbm_pkg::ADDR_OSC_TEST
        && reg_wdata[1:0] == 2'h0 ##1 !reg_wr |-> ##1 !osc_run_continuous)
        else $error("osc not normal");
    AST_START_PULSE: assert property (meas_start |=> !meas_start)
        else $error("start longer than one cycle");
    AST_REMOTE_NEXT: assert property (remote_rsp_valid
        && remote_cmd_code == tbm_pkg::REMOTE_CMD_SUPPLY
        |-> ##[1:2] (remote_cmd_valid && remote_cmd_code == tbm_pkg::REMOTE_CMD_TEMP))
        else $error("temperature fetch missing");
endmodule : tbm_readout_checker

bind tbm_readout tbm_readout_checker u_tbm_readout_checker (.core_clk, .reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mission_mode, .sleep_mode, .meas_start,
    .osc_run_continuous, .battery_load_on, .remote_rsp_valid, .remote_cmd_valid,
    .remote_cmd_code);

`default_nettype wire

/* tb/tbm_sense_model.sv */
// Purpose: sensor circuit and remote sensor stand-in
// Assumes: lag of 1..15 cycles per answer
// Notes:   data toggle when not valid
`default_nettype none

module tbm_sense_model (
    input wire logic         core_clk,
    input wire logic         meas_start,
    input wire logic         battery_load_on,
    input wire logic         remote_cmd_valid,
    input wire logic [1:0]   remote_cmd_code,
    input wire logic [10:0]  temp_val,
    input wire logic [7:0]   batt_val,
    input wire logic [3:0]   lag,
    output var logic         meas_done = 1'b0,
    output var logic [10:0]  meas_temp = 11'h000,
    output var logic [7:0]   meas_batt = 8'h00,
    output var logic         remote_rsp_valid = 1'b0,
    output var logic [10:0]  remote_rsp_data = 11'h000
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] mcnt_q = 4'h0;
    logic [3:0] rcnt_q = 4'h0;
    logic [1:0] code_q = 2'h0;

    // stale values never look valid
    always @(posedge core_clk) begin
        meas_done <= mcnt_q == 4'h1;
        meas_temp <= (mcnt_q == 4'h1) ? temp_val : ~meas_temp;
        meas_batt <= (mcnt_q == 4'h1) ? batt_val - (battery_load_on ? 8'h10 : 8'h00)
                                      : ~meas_batt;
        mcnt_q <= meas_start ? lag : ((mcnt_q != 4'h0) ? mcnt_q - 4'h1 : 4'h0);
    end

    always @(posedge core_clk) begin
        remote_rsp_valid <= rcnt_q == 4'h1;
        remote_rsp_data <= (rcnt_q != 4'h1) ? ~remote_rsp_data
            : (code_q == tbm_pkg::REMOTE_CMD_SUPPLY) ? {3'h0, batt_val} : temp_val;
        rcnt_q <= remote_cmd_valid ? lag : ((rcnt_q != 4'h0) ? rcnt_q - 4'h1 : 4'h0);
        if (remote_cmd_valid) begin
            code_q <= remote_cmd_code;
        end
    end
endmodule : tbm_sense_model

`default_nettype wire

/* tb/test_tbm_readout.sv */
// Purpose: self-checking bench of the monitor readout
// Assumes: TICK_CYCLES of 10 keeps interval runs short
// Notes:   reads queue their expectation, a monitor compares
`default_nettype none

module test_tbm_readout;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, mission_mode = 1, sleep_mode = 0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, meas_batt, batt_val = 8'h00, last_b = 8'h00;
    logic [10:0] meas_temp, remote_rsp_data, temp_val = 11'h000;
    logic meas_done, meas_start, meas_batt_en, osc_run_continuous, sensor_pwr_sel;
    logic battery_load_on, remote_rsp_valid, remote_cmd_valid, rd_pend = 0;
    logic [1:0] remote_cmd_code;
    logic [3:0] lag = 4'h1;
    logic [7:0] exp_q[$];
    int bad_count = 0, total_checks = 0, starts = 0, cmds = 0;
    integer seed = 32'hc339fd43;

    always #50 core_clk = ~core_clk;

    tbm_readout #(.TICK_CYCLES(10)) u_tbm_readout (.core_clk, .reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .mission_mode, .sleep_mode, .meas_done, .meas_temp,
        .meas_batt, .meas_start, .meas_batt_en, .osc_run_continuous, .sensor_pwr_sel,
        .battery_load_on, .remote_rsp_valid, .remote_rsp_data, .remote_cmd_valid,
        .remote_cmd_code);
    tbm_sense_model u_tbm_sense_model (.core_clk, .meas_start, .battery_load_on,
        .remote_cmd_valid, .remote_cmd_code, .temp_val, .batt_val, .lag, .meas_done,
        .meas_temp, .meas_batt, .remote_rsp_valid, .remote_rsp_data);

    task automatic check(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR at %0t: mismatch", $time);
        end
    endtask : check

    task automatic report_and_stop();
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask : bus

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd

    task automatic nop(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask : nop

    // one manual measurement, then its results read back
    task automatic measure(input logic with_b, input logic [7:0] drop);
        int n;
        temp_val = $random(seed);
        batt_val = $random(seed);
        lag = 4'(($random(seed) & 7) + 1);
        bus(1'b1, 16'h28b4, 8'h40);
        nop(1);
        n = 0;
        while (meas_done !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        check(n < 40);
        check(meas_batt_en === with_b);
        if (with_b) last_b = batt_val - drop;
        nop(2);
        rd(16'h2881, temp_val[10:3]);
        rd(16'h2882, {temp_val[2:0], 5'h00});
        rd(16'h2885, last_b);
        rd(16'h28b4, 8'h00);
        nop(3);
    endtask : measure

    always @(posedge core_clk) begin
        if (rd_pend) check(reg_rdata === exp_q.pop_front());
        rd_pend <= reg_rd;
        if (meas_start === 1'b1) starts++;
        if (remote_cmd_valid === 1'b1) cmds++;
    end

    initial begin
        int n;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        nop(1);
        rd(16'h2704, 8'h00);
        rd(16'h1234, 8'h00);
        for (int c = 3; c >= 0; c--) begin
            bus(1'b1, 16'h2500, 8'(c));
            nop(3);
            check(osc_run_continuous === (c != 0));
            rd(16'h2500, 8'(c));
        end
        bus(1'b1, 16'h28a0, 8'h50);
        measure(1'b1, 8'h00);
        bus(1'b1, 16'h2885, 8'hff);
        rd(16'h2885, last_b);
        bus(1'b1, 16'h2704, 8'h08);
        nop(3);
        check(battery_load_on === 1'b1);
        check(sensor_pwr_sel === 1'b1);
        measure(1'b1, 8'h10);
        sleep_mode <= 1'b1;
        nop(3);
        check(battery_load_on === 1'b0);
        check(sensor_pwr_sel === 1'b0);
        n = starts;
        bus(1'b1, 16'h28b4, 8'h40);
        nop(20);
        check(starts == n);
        sleep_mode <= 1'b0;
        mission_mode <= 1'b0;
        nop(3);
        check(battery_load_on === 1'b0);
        mission_mode <= 1'b1;
        bus(1'b1, 16'h2704, 8'h00);
        bus(1'b1, 16'h28a0, 8'h00);
        measure(1'b0, 8'h00);
        n = starts;
        bus(1'b1, 16'h28a0, 8'h01);
        nop(400);
        check(starts == n + 2);
        n = starts;
        bus(1'b1, 16'h28a0, 8'h07);
        nop(60);
        check(starts > n + 3);
        bus(1'b1, 16'h28a0, 8'h00);
        nop(20);
        n = cmds;
        bus(1'b1, 16'h28b8, 8'h01);
        nop(40);
        check(cmds == n + 2);
        rd(16'h28b9, batt_val);
        rd(16'h28ba, temp_val[10:3]);
        nop(3);
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        report_and_stop();
    end
endmodule : test_tbm_readout

`default_nettype wire
